// >>> rtl/oms_mode_dec.sv
// combinational decode of the latched mode code
`timescale 1ns/1ns
module oms_mode_dec
	import oms_pkg::*;
(
	input wire logic [2:0] i_code,
	output logic o_special,
	output logic o_single,
	output logic o_wide,
	output logic o_narrow,
	output logic o_periph
);
	// ==========================================
	// decode
	// reserved forced peripheral
	always_comb begin
		o_special = 1'b0;
		o_single = 1'b0;
		o_wide = 1'b0;
		o_narrow = 1'b0;
		o_periph = 1'b0;
		unique case (oms_mode_t'(i_code))
			OMS_SSC: begin
				o_special = 1'b1;
				o_single = 1'b1;
			end
			OMS_SXN: begin
				o_special = 1'b1;
				o_narrow = 1'b1;
			end
			OMS_SPER, OMS_RSVD: begin
				o_special = 1'b1;
				o_periph = 1'b1;
			end
			OMS_SXW: begin
				o_special = 1'b1;
				o_wide = 1'b1;
			end
			OMS_NSC: o_single = 1'b1;
			OMS_NXN: o_narrow = 1'b1;
			OMS_NXW: o_wide = 1'b1;
		endcase
	end
endmodule : oms_mode_dec

// >>> rtl/oms_pkg.sv
// shared constants for the operating mode select block
package oms_pkg;
	// ==========================================
	// mode codes {special_mode_n, hi, lo}
	typedef enum logic [2:0] {
		OMS_SSC = 3'h0,
		OMS_SXN = 3'h1,
		OMS_SPER = 3'h2,
		OMS_SXW = 3'h3,
		OMS_NSC = 3'h4,
		OMS_NXN = 3'h5,
		OMS_RSVD = 3'h6,
		OMS_NXW = 3'h7
	} oms_mode_t;
	// ==========================================
	// register offsets
	localparam logic [7:0] OMS_ADR_MODE = 8'h0B;
	localparam logic [7:0] OMS_ADR_PORTA = 8'h00;
	localparam logic [7:0] OMS_ADR_PORTB = 8'h01;
	localparam logic [7:0] OMS_ADR_DIRA = 8'h02;
	localparam logic [7:0] OMS_ADR_DIRB = 8'h03;
	localparam logic [7:0] OMS_ADR_PORT_E = 8'h08;
	localparam logic [7:0] OMS_ADR_DIRE = 8'h09;
	localparam logic [7:0] OMS_ADR_PUCR = 8'h0C;
	// ==========================================
	// mode register fields
	localparam int OMS_B_SPEC_N = 7;
	localparam int OMS_B_MODE_HI = 6;
	localparam int OMS_B_MODE_LO = 5;
	localparam int OMS_B_EMUL = 0;
	// pull control fields: bit0 port a, bit1 port b, bit4 port e
	localparam int OMS_B_PUA = 0;
	localparam int OMS_B_PUB = 1;
	localparam int OMS_B_PUE = 4;
	localparam logic [7:0] OMS_PUCR_RST = 8'h10;
	localparam logic [7:0] OMS_ZERO8 = 8'h00;
	// port e pins 1 and 0 are input only
	localparam logic [7:0] OMS_PE_IN_ONLY = 8'h03;
	// port e pins that carry bus control in special expanded wide mode
	localparam logic [7:0] OMS_PE_BUS_CTL = 8'hFC;
endpackage : oms_pkg

// >>> rtl/oms_top.sv
// operating mode select, port function and register visibility
// ==========================================
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ns
module oms_top
	import oms_pkg::*;
#(
	parameter int W = 8
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_debug_pin,
	input wire logic i_mode_pin_hi,
	input wire logic i_mode_pin_lo,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_dbg_enable_cmd,
	input wire logic i_dbg_active_cmd,
	input wire logic i_ext16_req,
	output logic o_pull_up_debug,
	output logic o_pull_dn_mode,
	output logic o_bus_wide,
	output logic o_bus_narrow,
	output logic o_narrow_hi_phase,
	output logic o_narrow_lo_phase,
	output logic o_gpio_ab,
	output logic [W-1:0] o_pe_bus_ctl,
	output logic [W-1:0] o_pe_pull_en,
	output logic o_pa_pull_en,
	output logic o_pb_pull_en,
	output logic [W-1:0] o_pa_oe,
	output logic [W-1:0] o_pb_oe,
	output logic [W-1:0] o_pe_oe,
	output logic [W-1:0] o_pa_out,
	output logic [W-1:0] o_pb_out,
	output logic [W-1:0] o_pe_out,
	output logic o_cpu_run,
	output logic o_skip_vector,
	output logic o_dbg_enabled,
	output logic o_dbg_active,
	output logic o_ab_regs_vis,
	output logic o_e_regs_vis,
	output logic o_special_mode_n
);
	// ==========================================
	// pin synchronisers
	logic [2:0] pin_s1_r;
	logic [2:0] pin_s2_r;
	always_ff @(posedge i_clk) begin
		pin_s1_r <= {i_debug_pin, i_mode_pin_hi, i_mode_pin_lo};
		pin_s2_r <= pin_s1_r;
	end

	// ==========================================
	// mode register state
	logic [2:0] code_r, code_nxt;
	logic emul_r, emul_nxt;
	logic lo_wr_done_r, lo_wr_done_nxt;
	logic sm_wr_seen_r, sm_wr_seen_nxt;
	logic emul_wr_seen_r, emul_wr_seen_nxt;
	logic rst_d_r;
	logic [7:0] pa_r, pa_nxt, pb_r, pb_nxt, da_r, da_nxt, db_r, db_nxt;
	logic [7:0] pe_r, pe_nxt, de_r, de_nxt, pucr_r, pucr_nxt;
	logic [7:0] rdata_nxt;
	logic dbg_en_r, dbg_en_nxt, dbg_act_r, dbg_act_nxt;
	logic hi_phase_r, hi_phase_nxt, lo_phase_r, lo_phase_nxt;
	logic special, single, wide, narrow, periph;
	logic [2:0] wr_code;

	oms_mode_dec u_dec (
		.i_code(code_r),
		.o_special(special),
		.o_single(single),
		.o_wide(wide),
		.o_narrow(narrow),
		.o_periph(periph)
	);

	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction : hit

	// port a, b and e map visibility
	assign o_ab_regs_vis = single;
	assign o_e_regs_vis = single | (!periph & !emul_r);

	always_comb begin
		code_nxt = code_r;
		emul_nxt = emul_r;
		lo_wr_done_nxt = lo_wr_done_r;
		sm_wr_seen_nxt = sm_wr_seen_r;
		emul_wr_seen_nxt = emul_wr_seen_r;
		pa_nxt = pa_r;
		pb_nxt = pb_r;
		da_nxt = da_r;
		db_nxt = db_r;
		pe_nxt = pe_r;
		de_nxt = de_r;
		pucr_nxt = pucr_r;
		wr_code = {i_wdata[OMS_B_SPEC_N], i_wdata[OMS_B_MODE_HI],
			i_wdata[OMS_B_MODE_LO]};
		// latch pins at release of reset
		if (rst_d_r) begin
			code_nxt = pin_s2_r;
			emul_nxt = !pin_s2_r[2];
		end else if (i_wr && hit(i_addr, OMS_ADR_MODE) && !periph) begin
			if (!code_r[2]) begin
				sm_wr_seen_nxt = 1'b1;
				if (sm_wr_seen_r)
					code_nxt[2] = wr_code[2];
			end
			if ((!code_r[2] || !lo_wr_done_r) &&
				{code_nxt[2], wr_code[1:0]} != OMS_SPER &&
				{code_nxt[2], wr_code[1:0]} != OMS_RSVD) begin
				code_nxt[1:0] = wr_code[1:0];
			end
			if (code_r[2])
				lo_wr_done_nxt = 1'b1;
			// emulation bit: once normal, special skips first
			if (code_r[2] ? !emul_wr_seen_r : emul_wr_seen_r)
				emul_nxt = i_wdata[OMS_B_EMUL];
			emul_wr_seen_nxt = 1'b1;
		end else if (i_wr) begin
			if (hit(i_addr, OMS_ADR_PORTA) && o_ab_regs_vis)
				pa_nxt = i_wdata;
			if (hit(i_addr, OMS_ADR_PORTB) && o_ab_regs_vis)
				pb_nxt = i_wdata;
			if (hit(i_addr, OMS_ADR_DIRA) && o_ab_regs_vis)
				da_nxt = i_wdata;
			if (hit(i_addr, OMS_ADR_DIRB) && o_ab_regs_vis)
				db_nxt = i_wdata;
			if (hit(i_addr, OMS_ADR_PORT_E) && o_e_regs_vis)
				pe_nxt = i_wdata;
			if (hit(i_addr, OMS_ADR_DIRE) && o_e_regs_vis)
				de_nxt = i_wdata & ~OMS_PE_IN_ONLY;
			if (hit(i_addr, OMS_ADR_PUCR))
				pucr_nxt = i_wdata;
		end
	end

	// ==========================================
	// read path, unmapped reads as zero
	// mode bits readable outside peripheral mode
	always_comb begin
		rdata_nxt = OMS_ZERO8;
		if (i_rd) begin
			if (hit(i_addr, OMS_ADR_MODE) && !periph) begin
				rdata_nxt[OMS_B_SPEC_N] = code_r[2];
				rdata_nxt[OMS_B_MODE_HI] = code_r[1];
				rdata_nxt[OMS_B_MODE_LO] = code_r[0];
				rdata_nxt[OMS_B_EMUL] = emul_r;
			end else if (hit(i_addr, OMS_ADR_PORTA) && o_ab_regs_vis)
				rdata_nxt = pa_r;
			else if (hit(i_addr, OMS_ADR_PORTB) && o_ab_regs_vis)
				rdata_nxt = pb_r;
			else if (hit(i_addr, OMS_ADR_DIRA) && o_ab_regs_vis)
				rdata_nxt = da_r;
			else if (hit(i_addr, OMS_ADR_DIRB) && o_ab_regs_vis)
				rdata_nxt = db_r;
			else if (hit(i_addr, OMS_ADR_PORT_E) && o_e_regs_vis)
				rdata_nxt = pe_r;
			else if (hit(i_addr, OMS_ADR_DIRE) && o_e_regs_vis)
				rdata_nxt = de_r;
			else if (hit(i_addr, OMS_ADR_PUCR))
				rdata_nxt = pucr_r;
		end
	end

	// ==========================================
	// debug monitor and narrow split
	always_comb begin
		dbg_en_nxt = dbg_en_r;
		dbg_act_nxt = dbg_act_r;
		// special single chip: active at once
		if (rst_d_r) begin
			dbg_en_nxt = pin_s2_r == OMS_SSC;
			dbg_act_nxt = pin_s2_r == OMS_SSC;
		end else begin
			if (i_dbg_enable_cmd)
				dbg_en_nxt = 1'b1;
			if (i_dbg_active_cmd && dbg_en_r && !periph)
				dbg_act_nxt = 1'b1;
		end
		// high byte cycle, then low byte
		hi_phase_nxt = narrow && i_ext16_req && !hi_phase_r;
		lo_phase_nxt = hi_phase_r;
	end

	always_ff @(posedge i_clk) begin
		rst_d_r <= i_rst;
		if (i_rst) begin
			// reset values give normal single chip
			code_r <= OMS_NSC;
			emul_r <= 1'b0;
			lo_wr_done_r <= 1'b0;
			sm_wr_seen_r <= 1'b0;
			emul_wr_seen_r <= 1'b0;
			pa_r <= OMS_ZERO8;
			pb_r <= OMS_ZERO8;
			da_r <= OMS_ZERO8;
			db_r <= OMS_ZERO8;
			pe_r <= OMS_ZERO8;
			de_r <= OMS_ZERO8;
			pucr_r <= OMS_PUCR_RST;
			o_rdata <= OMS_ZERO8;
			dbg_en_r <= 1'b0;
			dbg_act_r <= 1'b0;
			hi_phase_r <= 1'b0;
			lo_phase_r <= 1'b0;
		end else begin
			code_r <= code_nxt;
			emul_r <= emul_nxt;
			lo_wr_done_r <= lo_wr_done_nxt;
			sm_wr_seen_r <= sm_wr_seen_nxt;
			emul_wr_seen_r <= emul_wr_seen_nxt;
			pa_r <= pa_nxt;
			pb_r <= pb_nxt;
			da_r <= da_nxt;
			db_r <= db_nxt;
			pe_r <= pe_nxt;
			de_r <= de_nxt;
			pucr_r <= pucr_nxt;
			o_rdata <= rdata_nxt;
			dbg_en_r <= dbg_en_nxt;
			dbg_act_r <= dbg_act_nxt;
			hi_phase_r <= hi_phase_nxt;
			lo_phase_r <= lo_phase_nxt;
		end
	end

	// ==========================================
	// port functions
	// pulls only while reset is held
	assign o_pull_up_debug = i_rst;
	assign o_pull_dn_mode = i_rst;
	assign o_bus_wide = wide | periph;
	assign o_bus_narrow = narrow;
	assign o_narrow_hi_phase = hi_phase_r;
	assign o_narrow_lo_phase = lo_phase_r;
	// general purpose ports in single chip
	assign o_gpio_ab = single;
	assign o_pa_oe = single ? W'(da_r) : '0;
	assign o_pb_oe = single ? W'(db_r) : '0;
	assign o_pa_out = W'(pa_r);
	assign o_pb_out = W'(pb_r);
	// bus control pins on port e
	assign o_pe_bus_ctl = (code_r == OMS_SXW) ? W'(OMS_PE_BUS_CTL) : '0;
	assign o_pe_oe = W'((de_r |
		((code_r == OMS_SXW) ? OMS_PE_BUS_CTL : OMS_ZERO8)) &
		~OMS_PE_IN_ONLY);
	assign o_pe_out = W'(pe_r);
	assign o_pe_pull_en = pucr_r[OMS_B_PUE] ? '1 : W'(OMS_PE_IN_ONLY);
	assign o_pa_pull_en = pucr_r[OMS_B_PUA];
	assign o_pb_pull_en = pucr_r[OMS_B_PUB];
	assign o_cpu_run = !periph && !dbg_act_r;
	assign o_skip_vector = code_r == OMS_SSC;
	assign o_dbg_enabled = dbg_en_r;
	assign o_dbg_active = dbg_act_r;
	assign o_special_mode_n = code_r[2];

	// ==========================================
	// checks
	split_order_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_narrow_hi_phase |=> o_narrow_lo_phase)
		else $error("low byte did not follow high byte");
	periph_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
		!rst_d_r && !periph |=> !periph)
		else $error("peripheral mode entered without reset");
	ab_hide_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(wide || narrow || periph) |-> !o_ab_regs_vis)
		else $error("port a or b registers visible");
	dbg_seq_a: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(o_dbg_active) && !$past(rst_d_r) |-> $past(dbg_en_r))
		else $error("debug active without enable");
	latch_a: assert property (@(posedge i_clk)
		rst_d_r && !i_rst |=> code_r == $past(pin_s2_r))
		else $error("mode not latched at release");
	cpu_idle_a: assert property (@(posedge i_clk) disable iff (i_rst)
		periph |-> !o_cpu_run)
		else $error("processor runs in peripheral mode");
	e_vis_a: assert property (@(posedge i_clk) disable iff (i_rst)
		single |-> o_e_regs_vis)
		else $error("port e hidden in single chip");
	ssc_dbg_a: assert property (@(posedge i_clk) disable iff (i_rst)
		rst_d_r && pin_s2_r == OMS_SSC |=> o_dbg_active)
		else $error("debug monitor not active");
endmodule : oms_top

// >>> verification/oms_strap_model.sv
// strap pin model: drives or leaves open the three mode straps
`timescale 1ns/1ns
module oms_strap_model (
	input wire logic i_clk,
	input wire logic i_pu,
	input wire logic i_pd,
	input wire logic [2:0] i_open,
	input wire logic [2:0] i_lvl,
	output logic [2:0] o_pin
);
	logic [2:0] flt_r;
	// ==========================================
	// open pins with no pull wander, so a missing pull is seen
	initial flt_r = 3'h5;
	always @(posedge i_clk) flt_r <= ~flt_r;
	always_comb begin
		o_pin = i_lvl;
		if (i_open[2]) o_pin[2] = i_pu ? 1'b1 : flt_r[2];
		for (int i = 0; i < 2; i++)
			if (i_open[i]) o_pin[i] = i_pd ? 1'b0 : flt_r[i];
	end
endmodule : oms_strap_model

// >>> verification/operating_mode_select_test.sv
// self-checking bench for the operating mode select block
`timescale 1ns/1ns
module operating_mode_select_test;
	import oms_pkg::*;
`define CHK(nm, e, g) chk(nm, 8'(e), 8'(g))
	logic clk, rst, wr, rd, den, dact, x16, rd_d;
	logic [7:0] addr, wdata, rdata, pe_ctl, pa_oe, pe_pu, rv;
	logic [2:0] open_m, lvl, pin, k;
	logic wide, nar_o, hi_ph, lo_ph, gpio, pa_pu, pb_pu, run, skipv;
	logic den_o, dact_o, abv, ev, pu, pd, per, sgl, smn;
	logic [7:0] pb_oe, pe_oe, pa_o, pb_o, pe_o;
	logic [7:0] exp_q[$];
	int err_total = 0;
	int n_checks = 0;
	oms_strap_model strap (.i_clk(clk), .i_pu(pu), .i_pd(pd),
		.i_open(open_m), .i_lvl(lvl), .o_pin(pin));
	oms_top dut (.i_clk(clk), .i_rst(rst), .i_debug_pin(pin[2]),
		.i_mode_pin_hi(pin[1]), .i_mode_pin_lo(pin[0]), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
		.i_dbg_enable_cmd(den), .i_dbg_active_cmd(dact),
		.i_ext16_req(x16), .o_pull_up_debug(pu), .o_pull_dn_mode(pd),
		.o_bus_wide(wide), .o_bus_narrow(nar_o), .o_narrow_hi_phase(hi_ph),
		.o_narrow_lo_phase(lo_ph), .o_gpio_ab(gpio), .o_pe_bus_ctl(pe_ctl),
		.o_pe_pull_en(pe_pu), .o_pa_pull_en(pa_pu), .o_pb_pull_en(pb_pu),
		.o_pa_oe(pa_oe), .o_pb_oe(pb_oe), .o_pe_oe(pe_oe), .o_pa_out(pa_o),
		.o_pb_out(pb_o), .o_pe_out(pe_o), .o_cpu_run(run),
		.o_skip_vector(skipv), .o_dbg_enabled(den_o),
		.o_dbg_active(dact_o), .o_ab_regs_vis(abv), .o_e_regs_vis(ev),
		.o_special_mode_n(smn));
	// ==========================================
	// helpers
	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : stop_test
	task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic wr_reg(logic [7:0] a, logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(logic [7:0] a, logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		rd <= 1'b0;
	endtask : rd_reg
	task automatic cmd(int w);
		@(posedge clk);
		den <= (w == 0);
		dact <= (w == 1);
		x16 <= (w == 2);
		@(posedge clk);
		{den, dact, x16} <= 3'h0;
		@(negedge clk);
	endtask : cmd
	task automatic boot(logic [2:0] c, logic [2:0] op);
		@(posedge clk);
		open_m <= op;
		lvl <= c;
		rst <= 1'b1;
		repeat (8) @(posedge clk);
		`CHK("pulls", 2'h3, {pu, pd});
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask : boot
	// ==========================================
	// read data stand only in the cycle after the strobe
	always @(posedge clk) rd_d <= rd;
	always @(negedge clk) begin
		if (rd_d && exp_q.size() > 0)
			`CHK("rdata", exp_q.pop_front(), rdata);
	end
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		stop_test();
	end
	// ==========================================
	// main sequence
	initial begin
		{rst, wr, rd, den, dact, x16} = 6'h20;
		addr = 8'h00;
		wdata = 8'h00;
		open_m = 3'h0;
		lvl = 3'h4;
		void'($urandom(32'hFF23CC2C));
		for (int c = 0; c < 8; c++) begin
			k = 3'(c);
			per = (k[1:0] == 2'h2);
			sgl = (k[1:0] == 2'h0);
			boot(k, 3'h0);
			`CHK("wide", k[1], wide);
			`CHK("narrow", k[1:0] == 2'h1, nar_o);
			`CHK("gpio", sgl, gpio);
			`CHK("abvis", sgl, abv);
			`CHK("evis", sgl | (k[2] & ~per), ev);
			// debug monitor owns the processor in special single chip
			`CHK("run", ~per & (k != 3'h0), run);
			`CHK("smn", k[2], smn);
			`CHK("skip", k == 3'h0, skipv);
			`CHK("dbgact", k == 3'h0, dact_o);
			`CHK("busctl", k == 3'h3 ? 8'hFC : 8'h00, pe_ctl);
			`CHK("pullab", 2'h0, {pa_pu, pb_pu});
			`CHK("pulle", 8'hFF, pe_pu);
			rd_reg(OMS_ADR_MODE, per ? 8'h00 : {k, 4'h0, ~k[2]});
			lvl <= ~k;
			repeat (4) @(posedge clk);
			@(negedge clk);
			`CHK("latch", sgl, gpio);
		end
		boot(3'h0, 3'h7);
		`CHK("open", 1'b1, gpio);
		`CHK("hiz", 8'h00, pa_oe);
		`CHK("hiz_b", 8'h00, pb_oe);
		`CHK("hiz_e", 8'h00, pe_oe);
		rd_reg(OMS_ADR_MODE, 8'h80);
		rv = 8'($urandom);
		wr_reg(OMS_ADR_DIRA, rv);
		rd_reg(OMS_ADR_DIRA, rv);
		rd_reg(8'h7F, 8'h00);
		@(negedge clk);
		`CHK("pa_oe", rv, pa_oe);
		wr_reg(OMS_ADR_PORTA, rv);
		wr_reg(OMS_ADR_PORTB, ~rv);
		wr_reg(OMS_ADR_DIRB, ~rv);
		wr_reg(OMS_ADR_PORT_E, rv);
		wr_reg(OMS_ADR_DIRE, 8'hFF);
		// input-only port e pins never turn into outputs
		rd_reg(OMS_ADR_DIRE, 8'hFC);
		@(negedge clk);
		`CHK("pa_out", rv, pa_o);
		`CHK("pb_out", ~rv, pb_o);
		`CHK("pb_oe", ~rv, pb_oe);
		`CHK("pe_out", rv, pe_o);
		`CHK("pe_oe", 8'hFC, pe_oe);
		cmd(1);
		`CHK("dbg_early", 1'b0, dact_o);
		cmd(0);
		`CHK("dbg_en", 1'b1, den_o);
		cmd(1);
		`CHK("dbg_on", 1'b1, dact_o);
		wr_reg(OMS_ADR_MODE, 8'hE0);
		@(negedge clk);
		`CHK("sw_wide", 1'b1, wide);
		`CHK("sw_abvis", 1'b0, abv);
		wr_reg(OMS_ADR_MODE, 8'hA0);
		rd_reg(OMS_ADR_MODE, 8'hE0);
		rd_reg(OMS_ADR_DIRA, 8'h00);
		boot(3'h0, 3'h0);
		wr_reg(OMS_ADR_MODE, 8'h41);
		rd_reg(OMS_ADR_MODE, 8'h01);
		wr_reg(OMS_ADR_MODE, 8'h61);
		rd_reg(OMS_ADR_MODE, 8'h61);
		@(negedge clk);
		`CHK("sw_busctl", 8'hFC, pe_ctl);
		`CHK("sw_pe_oe", 8'hFC, pe_oe);
		wr_reg(OMS_ADR_MODE, 8'h21);
		rd_reg(OMS_ADR_MODE, 8'h21);
		@(negedge clk);
		`CHK("emul_hide", 1'b0, ev);
		boot(3'h5, 3'h0);
		cmd(2);
		`CHK("hi_ph", 2'h2, {hi_ph, lo_ph});
		@(negedge clk);
		`CHK("lo_ph", 2'h1, {hi_ph, lo_ph});
		// mode writes cannot leave the peripheral mode; processor stays idle
		boot(3'h2, 3'h0);
		wr_reg(OMS_ADR_MODE, 8'hE0);
		@(negedge clk);
		`CHK("per_stay", 1'b0, run);
		repeat (3) @(posedge clk);
		stop_test();
	end
endmodule : operating_mode_select_test
